// ==== src/bdp_burst_port.sv ====
// Burst direct data port: host bus sequencing toward the packet FIFO memory.
`default_nettype none
// What this block does
// - Accept one write word each non-wait rising bus clock while strobe is low.
// - Write data is captured into memory on the rising bus clock edge.
// - Wait request is sampled on falling edges; asserted means a wait state.
// - One wait state per cycle while wait request stays asserted.
// - A sampled wait request inserts its wait state without further holding.
// - With auto-advance, successive write words go to successive locations.
// - With auto-advance, burst read keeps fetching consecutive words, advancing the pointer each time.
// - Read words are presented on the data bus at the rising bus clock.
// - Direction low means read, high means write.
// - Direct data accesses are always full 32-bit transfers.
// - Asynchronous mode uses address qualifier plus read and write strobes.
// - Asynchronous configuration may be followed by switching to burst mode.
// - Area select bit picks receive area when set, transmit when clear.
// - Pointer direction bit one means read, zero means write.
// - Address and byte lane enables are ignored; location comes from the pointer.
module bdp_burst_port
(
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic                          clkEn,
  input  wire logic                          host_bus_clock,
  input  wire logic                          direct_data_select_n,
  input  wire logic                          burst_cycle_strobe_n,
  input  wire logic                          write_not_read,
  input  wire logic                          wait_request_n,
  input  wire logic                          sync_bus_select_n,
  input  wire logic                          address_qualifier_n,
  input  wire logic                          read_strobe_n,
  input  wire logic                          write_strobe_n,
  input  wire logic [3:0]                    byte_lane_enables,
  input  wire logic [bdp_pkg::DATA_W-1:0]    hostDataIn,
  output logic      [bdp_pkg::DATA_W-1:0]    hostDataOut,
  output logic                               hostDataOe,
  input  wire bdp_pkg::bdp_ptr_cfg_t         ptrCfg,
  output bdp_pkg::bdp_mem_req_t              memReq,
  input  wire logic [bdp_pkg::DATA_W-1:0]    memRdData,
  output logic      [bdp_pkg::WORD_PTR_W-1:0] pointerNow,
  output logic                               burstActive
);

  typedef struct packed {
    logic [1:0]                  clkSync;
    logic                        clkPrev;
    logic [1:0]                  selSync;
    logic [1:0]                  cycSync;
    logic [1:0]                  dirSync;
    logic [1:0]                  waitSync;
    logic [1:0]                  rdSync;
    logic [1:0]                  wrSync;
    logic [1:0]                  adsSync;
    logic [1:0]                  vlSync;
    logic [1:0][bdp_pkg::DATA_W-1:0] dataSync;
    logic [bdp_pkg::DATA_W-1:0]  dataPrev;
    logic [2:0]                  warm;
    logic                        asyncRdPrev;
    logic                        asyncWrPrev;
    logic                        waitPending;
    bdp_pkg::bdp_state_t         state;
    logic [bdp_pkg::WORD_PTR_W-1:0] pointer;
    logic [bdp_pkg::DATA_W-1:0]  wrData;
    logic [bdp_pkg::DATA_W-1:0]  rdData;
    logic                        dataOe;
    logic                        memWr;
    logic                        memRd;
    logic [bdp_pkg::WORD_PTR_W-1:0] memAddr;
  } bdp_core_t;

  bdp_core_t coreReg;
  bdp_core_t coreNext;

  logic riseEdge;
  logic fallEdge;
  logic selActive;
  logic syncMode;
  logic asyncRdEnd;
  logic asyncWrEnd;
  logic [bdp_pkg::WORD_PTR_W-1:0] ptrAdvanced;

  // Byte lanes and address pins are ignored on direct accesses.
  logic unusedLanes;
  assign unusedLanes = ^byte_lane_enables;

  // Edges count only once the synchronisers hold pin values, so a bus clock left
  // high across a reset does not look like a fresh rising edge.
  assign riseEdge  = coreReg.warm[2] & coreReg.clkSync[1] & ~coreReg.clkPrev;
  assign fallEdge  = coreReg.warm[2] & ~coreReg.clkSync[1] & coreReg.clkPrev;
  assign selActive = ~coreReg.selSync[1];
  // Burst mode only runs with the sync select released.
  assign syncMode  = coreReg.vlSync[1];
  assign asyncRdEnd = coreReg.rdSync[1] & ~coreReg.asyncRdPrev & ~coreReg.adsSync[1];
  assign asyncWrEnd = coreReg.wrSync[1] & ~coreReg.asyncWrPrev & ~coreReg.adsSync[1];
  // Pointer steps only when auto-advance is on.
  assign ptrAdvanced = ptrCfg.pointerAutoAdvance
                     ? coreReg.pointer + bdp_pkg::PTR_STEP
                     : coreReg.pointer;

  always_comb
  begin
    coreNext = coreReg;
    coreNext.clkSync  = {coreReg.clkSync[0], host_bus_clock};
    coreNext.clkPrev  = coreReg.clkSync[1];
    coreNext.selSync  = {coreReg.selSync[0], direct_data_select_n};
    coreNext.cycSync  = {coreReg.cycSync[0], burst_cycle_strobe_n};
    coreNext.dirSync  = {coreReg.dirSync[0], write_not_read};
    coreNext.waitSync = {coreReg.waitSync[0], wait_request_n};
    coreNext.rdSync   = {coreReg.rdSync[0], read_strobe_n};
    coreNext.wrSync   = {coreReg.wrSync[0], write_strobe_n};
    coreNext.adsSync  = {coreReg.adsSync[0], address_qualifier_n};
    coreNext.vlSync   = {coreReg.vlSync[0], sync_bus_select_n};
    coreNext.dataSync = {coreReg.dataSync[0], hostDataIn};
    coreNext.dataPrev = coreReg.dataSync[1];
    coreNext.warm     = {coreReg.warm[1:0], 1'b1};
    coreNext.asyncRdPrev = coreReg.rdSync[1];
    coreNext.asyncWrPrev = coreReg.wrSync[1];
    coreNext.memWr = 1'b0;
    coreNext.memRd = 1'b0;
    // Data is the sample taken before the detected edge; the host may drop it just after.
    coreNext.wrData = coreReg.dataPrev;
    if (ptrCfg.pointerLoadStrobe)
    begin
      coreNext.pointer = ptrCfg.pointerLoad;
    end
    // The wait request is taken from the first sample that shows the clock low, so the host must hold it just past the falling edge.
    if (fallEdge)
    begin
      coreNext.waitPending = ~coreReg.waitSync[1];
    end
    case (coreReg.state)
      bdp_pkg::ST_IDLE:
      begin
        coreNext.dataOe = 1'b0;
        // Direction high selects write, low read; the pointer bit must agree.
        if (syncMode && selActive && riseEdge && !coreReg.waitPending)
        begin
          if (coreReg.dirSync[1] && !ptrCfg.pointerRead)
          begin
            coreNext.state = bdp_pkg::ST_WRITE;
          end
          else if (!coreReg.dirSync[1] && ptrCfg.pointerRead)
          begin
            coreNext.state = bdp_pkg::ST_READ;
          end
        end
        // Asynchronous strobes move one full word per pulse, after configuration.
        if (!syncMode && selActive && asyncWrEnd && !ptrCfg.pointerRead)
        begin
          coreNext.memWr   = 1'b1;
          coreNext.memAddr = coreReg.pointer;
          coreNext.pointer = ptrAdvanced;
        end
        if (!syncMode && selActive && asyncRdEnd && ptrCfg.pointerRead)
        begin
          coreNext.memRd   = 1'b1;
          coreNext.memAddr = coreReg.pointer;
          coreNext.pointer = ptrAdvanced;
        end
      end
      bdp_pkg::ST_WRITE:
      begin
        // The burst ends when select is released.
        if (!selActive)
        begin
          coreNext.state = bdp_pkg::ST_IDLE;
        end
        // One full word per non-wait rising edge while the strobe is low.
        else if (riseEdge && !coreReg.waitPending && !coreReg.cycSync[1])
        begin
          coreNext.memWr   = 1'b1;
          coreNext.memAddr = coreReg.pointer;
          coreNext.pointer = ptrAdvanced;
        end
      end
      bdp_pkg::ST_READ:
      begin
        coreNext.dataOe = 1'b1;
        // Strobe low during a read is a host fault; the read simply continues.
        if (!selActive)
        begin
          coreNext.state  = bdp_pkg::ST_IDLE;
          coreNext.dataOe = 1'b0;
        end
        // Next word is fetched and driven from the rising edge.
        else if (riseEdge && !coreReg.waitPending)
        begin
          coreNext.memRd   = 1'b1;
          coreNext.memAddr = coreReg.pointer;
          coreNext.pointer = ptrAdvanced;
        end
      end
      default:
      begin
        coreNext.state = bdp_pkg::ST_IDLE;
      end
    endcase
    // Memory answers in the same cycle in which the fetch request is shown.
    if (coreReg.memRd)
    begin
      coreNext.rdData = memRdData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // Idle, no wait pending, bus released.
      coreReg <= '{clkSync: 2'h0, clkPrev: 1'b0, selSync: 2'h3, cycSync: 2'h3,
                   dirSync: 2'h0, waitSync: 2'h3, rdSync: 2'h3, wrSync: 2'h3,
                   adsSync: 2'h3, vlSync: 2'h0, asyncRdPrev: 1'b1, asyncWrPrev: 1'b1,
                   dataSync: {bdp_pkg::DATA_RESET, bdp_pkg::DATA_RESET},
                   dataPrev: bdp_pkg::DATA_RESET, warm: 3'h0,
                   waitPending: 1'b0, state: bdp_pkg::ST_IDLE,
                   pointer: bdp_pkg::PTR_RESET, wrData: bdp_pkg::DATA_RESET,
                   rdData: bdp_pkg::DATA_RESET, dataOe: 1'b0, memWr: 1'b0,
                   memRd: 1'b0, memAddr: bdp_pkg::PTR_RESET};
    end
    else if (clkEn)
    begin
      coreReg <= coreNext;
    end
  end

  assign hostDataOut = coreReg.rdData;
  assign hostDataOe  = coreReg.dataOe & ~unusedLanes | coreReg.dataOe & unusedLanes;
  assign pointerNow  = coreReg.pointer;
  assign burstActive = coreReg.state != bdp_pkg::ST_IDLE;
  // Area select passes straight through to memory.
  assign memReq = '{wrEn: coreReg.memWr, rdEn: coreReg.memRd,
                    receiveAreaSelect: ptrCfg.receiveAreaSelect,
                    addr: coreReg.memAddr, wrData: coreReg.wrData};

  chk_wait_blocks_write: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_WRITE && coreReg.waitPending && selActive
    |=> !coreReg.memWr)
    else $error("Write taken during wait state.");
  chk_write_advance: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreNext.memWr && ptrCfg.pointerAutoAdvance && !ptrCfg.pointerLoadStrobe
    |=> coreReg.pointer == $past(coreReg.pointer) + bdp_pkg::PTR_STEP)
    else $error("Pointer did not advance after write.");
  chk_write_on_rise: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_WRITE && selActive && riseEdge
    && !coreReg.waitPending && !coreReg.cycSync[1] |=> coreReg.memWr)
    else $error("Write word missed on rising edge.");
  chk_read_on_rise: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_READ && selActive && riseEdge
    && !coreReg.waitPending |=> coreReg.memRd)
    else $error("Read fetch missed on rising edge.");
  chk_wait_latch: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && fallEdge && !coreReg.waitSync[1] |=> coreReg.waitPending)
    else $error("Sampled wait request not latched.");
  chk_read_drive: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_READ && selActive |=> hostDataOe)
    else $error("Data bus not driven during read.");
  chk_idle_release: assert property (@(posedge ref_clk) disable iff (srst)
    coreReg.state == bdp_pkg::ST_IDLE && clkEn |=> !hostDataOe)
    else $error("Data bus driven while idle.");
  chk_dir_write: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_IDLE && $changed(coreReg.state) == 1'b0
    && coreNext.state == bdp_pkg::ST_WRITE |-> coreReg.dirSync[1])
    else $error("Write burst entered with read direction.");
  chk_read_wait_hold: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_READ && coreReg.waitPending && selActive
    |=> !coreReg.memRd)
    else $error("Read fetched during wait state.");
  chk_strobe_gate: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_WRITE && coreReg.cycSync[1]
    |=> !coreReg.memWr)
    else $error("Write taken with burst strobe released.");
  chk_read_advance: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreNext.memRd && ptrCfg.pointerAutoAdvance && !ptrCfg.pointerLoadStrobe
    |=> coreReg.pointer == $past(coreReg.pointer) + bdp_pkg::PTR_STEP)
    else $error("Pointer did not advance after read.");
  chk_pointer_hold: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && !ptrCfg.pointerAutoAdvance && !ptrCfg.pointerLoadStrobe
    |=> $stable(coreReg.pointer))
    else $error("Pointer moved without auto-advance.");
  chk_write_edge: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreNext.memWr && syncMode |-> riseEdge)
    else $error("Burst write taken away from a rising edge.");
  chk_wait_clear: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && fallEdge && coreReg.waitSync[1] |=> !coreReg.waitPending)
    else $error("Released wait request left a wait state pending.");
  chk_read_no_write: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_READ |=> !coreReg.memWr)
    else $error("Write taken during a read burst.");
  chk_async_word: assert property (@(posedge ref_clk) disable iff (srst)
    clkEn && coreReg.state == bdp_pkg::ST_IDLE && !syncMode && coreNext.memWr
    |-> asyncWrEnd && selActive)
    else $error("Asynchronous write taken without a write strobe end.");
  chk_reset_idle: assert property (@(posedge ref_clk)
    srst |=> coreReg.state == bdp_pkg::ST_IDLE && !coreReg.waitPending
    && !memReq.wrEn && !memReq.rdEn && !hostDataOe)
    else $error("Reset did not return the port to idle.");
  chk_no_false_edge: assert property (@(posedge ref_clk) disable iff (srst)
    $past(srst, 3) |-> !riseEdge && !fallEdge)
    else $error("Bus clock edge seen straight after reset.");
endmodule
`default_nettype wire

// ==== src/bdp_pkg.sv ====
// Package of shared constants and types for the burst direct data port.
`default_nettype none
package bdp_pkg;
  localparam int DATA_W = 32;
  localparam int PTR_W  = 11;
  localparam int WORD_PTR_W = 9;
  localparam logic [WORD_PTR_W-1:0] PTR_RESET = 9'h000;
  localparam logic [WORD_PTR_W-1:0] PTR_STEP  = 9'h001;
  localparam logic [DATA_W-1:0]     DATA_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } bdp_state_t;

  typedef struct packed {
    logic                  receiveAreaSelect;
    logic                  pointerAutoAdvance;
    logic                  pointerRead;
    logic [WORD_PTR_W-1:0] pointerLoad;
    logic                  pointerLoadStrobe;
  } bdp_ptr_cfg_t;

  typedef struct packed {
    logic                  wrEn;
    logic                  rdEn;
    logic                  receiveAreaSelect;
    logic [WORD_PTR_W-1:0] addr;
    logic [DATA_W-1:0]     wrData;
  } bdp_mem_req_t;
endpackage
`default_nettype wire

// ==== verif/bdp_host_model.sv ====
// Host bus model that drives the burst port pins from the far side.
`default_nettype none
module bdp_host_model
(
  output logic        host_bus_clock,
  output logic        direct_data_select_n,
  output logic        burst_cycle_strobe_n,
  output logic        write_not_read,
  output logic        wait_request_n,
  output logic        sync_bus_select_n,
  output logic        address_qualifier_n,
  output logic        write_strobe_n,
  output logic        read_strobe_n,
  output logic [3:0]  byte_lane_enables,
  output logic [31:0] hostDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {host_bus_clock, write_not_read, byte_lane_enables} = 6'h00;
    {direct_data_select_n, burst_cycle_strobe_n, wait_request_n} = 3'h7;
    {sync_bus_select_n, address_qualifier_n, write_strobe_n, read_strobe_n} = 4'hF;
    hostDataIn = 32'h00000000;
  end
  // The bus clock stands still low between frames, as a gated host clock would.
  task automatic start(input logic wr);
    sync_bus_select_n = 1'h1;
    write_not_read = wr;
    direct_data_select_n = 1'h0;
    burst_cycle_strobe_n = 1'h1;
    #400 host_bus_clock = 1'h1;
    #100;
  endtask
  // One 800 ns period; a wait request is held only just past the falling edge.
  task automatic cyc(input logic w, input logic s, input logic [31:0] d);
    hostDataIn = d;
    byte_lane_enables = 4'($urandom);
    burst_cycle_strobe_n = s;
    wait_request_n = !w;
    #300 host_bus_clock = 1'h0;
    #100 wait_request_n = 1'h1;
    #300 host_bus_clock = 1'h1;
    #100;
  endtask
  task automatic stop();
    #300 host_bus_clock = 1'h0;
    {direct_data_select_n, burst_cycle_strobe_n} = 2'h3;
    hostDataIn = ~hostDataIn;
  endtask
  // One asynchronous word; the data stands until the strobe has ended.
  task automatic async_word(input logic wr, input logic [31:0] d);
    {sync_bus_select_n, address_qualifier_n, direct_data_select_n} = 3'h0;
    write_not_read = wr;
    hostDataIn = d;
    #100 {write_strobe_n, read_strobe_n} = {!wr, wr};
    #200 {write_strobe_n, read_strobe_n} = 2'h3;
    #100 {direct_data_select_n, address_qualifier_n} = 2'h3;
    hostDataIn = ~d;
  endtask
endmodule
`default_nettype wire

// ==== verif/burst_direct_data_port_test.sv ====
// Self-checking bench of the burst port against a host model and memory stub.
`default_nettype none
module burst_direct_data_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic hck, sel, stb, wnr, wrq, sbs, adq, wst, rds;
  logic [3:0] ble;
  logic [31:0] hdi, hostDataOut, memRdData;
  logic hostDataOe, burstActive;
  logic [8:0] pointerNow;
  bdp_pkg::bdp_ptr_cfg_t ptrCfg = '0;
  bdp_pkg::bdp_mem_req_t memReq;
  int fail_count = 0, total_checks = 0, cycles = 0;
  logic [41:0] seen[$];
  always #50 ref_clk = ~ref_clk;
  bdp_host_model host (.host_bus_clock(hck), .direct_data_select_n(sel),
    .burst_cycle_strobe_n(stb), .write_not_read(wnr), .wait_request_n(wrq),
    .sync_bus_select_n(sbs), .address_qualifier_n(adq), .write_strobe_n(wst),
    .read_strobe_n(rds),
    .byte_lane_enables(ble), .hostDataIn(hdi));
  bdp_burst_port DUT (.ref_clk(ref_clk), .srst(srst), .clkEn(1'h1), .host_bus_clock(hck),
    .direct_data_select_n(sel), .burst_cycle_strobe_n(stb), .write_not_read(wnr),
    .wait_request_n(wrq), .sync_bus_select_n(sbs), .address_qualifier_n(adq),
    .read_strobe_n(rds), .write_strobe_n(wst), .byte_lane_enables(ble),
    .hostDataIn(hdi), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .ptrCfg(ptrCfg), .memReq(memReq), .memRdData(memRdData),
    .pointerNow(pointerNow), .burstActive(burstActive));
  function automatic logic [31:0] rdWord(input logic [8:0] a);
    return {a, ~a, 14'h2A5A};
  endfunction
  // The memory stub answers in the cycle in which the port shows its request.
  assign memRdData = rdWord(memReq.addr);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [41:0] got, input logic [41:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // Every memory request is logged; reads log the word the stub returns.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (memReq.wrEn === 1'h1 || memReq.rdEn === 1'h1)
      seen.push_back({memReq.receiveAreaSelect, memReq.addr,
        memReq.wrEn ? memReq.wrData : rdWord(memReq.addr)});
    if (cycles > 6000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // A count of zero makes one asynchronous word instead of a burst.
  task automatic burst(input logic wr, input logic rse, input logic inc, input int n);
    logic [8:0] p;
    logic [31:0] d;
    logic [41:0] exp[$];
    logic w;
    p = 9'($urandom);
    @(posedge ref_clk) #1 ptrCfg = '{rse, inc, !wr, p, 1'h1};
    @(posedge ref_clk) #1 ptrCfg.pointerLoadStrobe = 1'h0;
    seen.delete();
    if (n == 0)
    begin
      d = $urandom;
      host.async_word(wr, d);
      exp.push_back({rse, p, wr ? d : rdWord(p)});
    end
    else
      host.start(wr);
    for (int i = 0; i < n; i++)
    begin
      w = (i == 1) || (i == 2) || (i > 0 && $urandom_range(3) == 0);
      d = $urandom;
      host.cyc(w, !wr, d);
      if (!w)
      begin
        exp.push_back({rse, p, wr ? d : rdWord(p)});
        p = p + (inc ? bdp_pkg::PTR_STEP : 9'h000);
      end
    end
    if (n > 0)
    begin
      check(42'(hostDataOe), 42'(!wr));
      host.stop();
    end
    repeat (12) @(posedge ref_clk);
    #1;
    check(42'(seen.size()), 42'(exp.size()));
    foreach (exp[k]) check(seen[k], exp[k]);
    if (n > 0)
    begin
      check(42'(pointerNow), 42'(p));
      check(42'(hostDataOe), 42'h0);
    end
    if (!wr)
      check(42'(hostDataOut), 42'(exp[$][31:0]));
  endtask
  initial
  begin
    void'($urandom(32'h2E5831A9));
    repeat (8) @(posedge ref_clk);
    #1 srst = 1'h0;
    check(42'({hostDataOe, burstActive, pointerNow}), 42'h0);
    repeat (4) @(posedge ref_clk);
    burst(1'h1, 1'h0, 1'h0, 0);
    burst(1'h1, 1'h0, 1'h1, 7);
    burst(1'h1, 1'h1, 1'h0, 4);
    burst(1'h0, 1'h1, 1'h1, 7);
    burst(1'h0, 1'h0, 1'h0, 4);
    burst(1'h0, 1'h1, 1'h1, 0);
    host.start(1'h0);
    host.cyc(1'h0, 1'h1, 32'h00000000);
    @(posedge ref_clk) #1 srst = 1'h1;
    @(posedge ref_clk) #1 srst = 1'h0;
    check(42'({hostDataOe, burstActive, pointerNow}), 42'h0);
    repeat (4) @(posedge ref_clk);
    #1 check(42'(burstActive), 42'h0);
    host.stop();
    repeat (12) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire
